// file: common/epi_pkg.sv
package epi_pkg;
  // ==========================================================
  // Register indices (printed offsets not all multiples of 4)
  localparam logic [7:0] IDX_MASK_LOW  = 8'h09;
  localparam logic [7:0] IDX_MASK_MID  = 8'h0a;
  localparam logic [7:0] IDX_FLAGS     = 8'h0b;
  localparam logic [7:0] IDX_ENABLES   = 8'h0c;
  localparam logic [7:0] IDX_MASK_HIGH = 8'h1a;
  localparam logic [7:0] IDX_SENSE     = 8'h20;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h21;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h22;
  // ==========================================================
  // Field layout
  localparam int PIN_BIT    = 0;
  localparam int GRP0_BIT   = 4;
  localparam int GRP1_BIT   = 5;
  localparam int GRP2_BIT   = 6;
  localparam int SENSE_LSB  = 6;
  localparam int GRP0_W     = 8;
  localparam int GRP1_W     = 4;
  localparam int GRP2_W     = 6;
  localparam int NUM_CHG    = 18;
  localparam int NUM_SRC    = 4;
  // Writable bits of each register
  localparam logic [7:0] WMASK_LOW  = 8'hff;
  localparam logic [7:0] WMASK_MID  = 8'h0f;
  localparam logic [7:0] WMASK_HIGH = 8'h3f;
  localparam logic [7:0] WMASK_GRP  = 8'h71;
  localparam logic [7:0] WMASK_SNS  = 8'hc0;
  localparam logic [7:0] RESET_VAL  = 8'h00;
  // ==========================================================
  // Sense modes of the dedicated pin
  typedef enum logic [1:0] {
    EPI_SENSE_LOW  = 2'h0,
    EPI_SENSE_ANY  = 2'h1,
    EPI_SENSE_FALL = 2'h2,
    EPI_SENSE_RISE = 2'h3
  } epi_sense_t;
  // Vector numbers on the acknowledge port
  localparam logic [1:0] VEC_PIN  = 2'h0;
  localparam logic [1:0] VEC_GRP0 = 2'h1;
  localparam logic [1:0] VEC_GRP1 = 2'h2;
  localparam logic [1:0] VEC_GRP2 = 2'h3;
  // AHB codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

// file: hdl/epi_change_group.sv
`timescale 1ns/1ps
// One pin-change group: per-pin edge detect, mask, or-reduce
module epi_change_group #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Pins and mask
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic [WIDTH-1:0] mask,
  // Result
  output logic                  changed
);
  logic [WIDTH-1:0] hit;

  // ==========================================================
  // Per-pin detectors
  for (genvar i = 0; i < WIDTH; i++) begin : gPin
    logic r;
    logic f;
    epi_edge_detect uDet (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pinIn   (pins[i]),
      .sampled (),
      .rise    (r),
      .fall    (f)
    );
    assign hit[i] = (r | f) & mask[i];
  end

  assign changed = |hit;
endmodule

// file: hdl/epi_edge_detect.sv
`timescale 1ns/1ps
// Samples one input and reports rise and fall of the sampled value
module epi_edge_detect (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Pin side
  input  wire logic pinIn,
  // Results
  output logic      sampled,
  output logic      rise,
  output logic      fall
);
  logic       prevSample;
  logic [1:0] warm;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sampled    <= 1'b0;
      prevSample <= 1'b0;
      warm       <= 2'h0;
    end else begin
      sampled    <= pinIn;
      prevSample <= sampled;
      warm       <= {warm[0], 1'b1};
    end
  end

  // No edge until both stages hold real pin levels: a pin idling
  // high would otherwise fake a rise right after reset
  assign rise = sampled & ~prevSample & warm[1];
  assign fall = ~sampled & prevSample & warm[1];
endmodule

// file: hdl/epi_ext_irq.sv
`timescale 1ns/1ps
// ==========================================================
// How it works
// - Bits 7:6 pick low, change, fall, rise
// - Pulses over one clock always detected
// - Edges found on sampled pin, not raw
// - Pin request needs enable bit and global
// - Pin level used even when driven out
// - Per-pin mask gates change into group
// - Group enables bits 6,5,4, global gated
// - Enabled group change sets flag bits 6,5,4
// - Flags clear on handler entry or one
// - Pin edge sets flag bit 0
// - Low-level mode keeps pin flag clear
// - Reserved bits read zero, ignore writes
// - Change detection sampled on clk_sys, no clockless path
// - Low level keeps request while low
module epi_ext_irq
  import epi_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Pins (dedicated pin level as seen at the pad)
  input  wire logic              dedicated_irq_pin,
  input  wire logic [epi_pkg::NUM_CHG-1:0] change_input,
  // Core handshake
  input  wire logic              globalIrqEnable,
  input  wire logic              vecAck,
  input  wire logic [1:0]        vecAckId,
  output logic [epi_pkg::NUM_SRC-1:0] coreRequest,
  // System interrupt
  output logic                   irqOut
);
  import epi_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] change_mask_group0;
  logic [7:0] change_mask_group1;
  logic [7:0] change_mask_group2;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_flag_reg;
  logic [7:0] sense_power_ctrl_reg;
  logic [NUM_SRC-1:0] eventStatus;
  logic [NUM_SRC-1:0] eventMask;

  // ==========================================================
  // AHB address phase capture
  logic       dataWrite;
  logic [7:0] dataIdx;
  wire        addrValid = hsel & hready &
                          (htrans == HTRANS_NONSEQ ||
                           htrans == HTRANS_SEQ);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dataWrite <= 1'b0;
      dataIdx   <= 8'h00;
    end else begin
      dataWrite <= addrValid & hwrite;
      if (addrValid) begin
        dataIdx <= haddr[9:2];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  function automatic logic wrHit(input logic [7:0] idx,
                                 input logic       we,
                                 input logic [7:0] cur);
    return we && (cur == idx);
  endfunction

  wire [7:0] wd      = hwdata[7:0];
  wire wrMaskLow     = wrHit(IDX_MASK_LOW,  dataWrite, dataIdx);
  wire wrMaskMid     = wrHit(IDX_MASK_MID,  dataWrite, dataIdx);
  wire wrMaskHigh    = wrHit(IDX_MASK_HIGH, dataWrite, dataIdx);
  wire wrEnables     = wrHit(IDX_ENABLES,   dataWrite, dataIdx);
  wire wrFlags       = wrHit(IDX_FLAGS,     dataWrite, dataIdx);
  wire wrSense       = wrHit(IDX_SENSE,     dataWrite, dataIdx);
  wire wrStat        = wrHit(IDX_IRQ_STAT,  dataWrite, dataIdx);
  wire wrIrqMask     = wrHit(IDX_IRQ_MASK,  dataWrite, dataIdx);

  // ==========================================================
  // Dedicated pin detection on the sampled level
  logic pinSampled;
  logic pinRise;
  logic pinFall;

  epi_edge_detect uPin (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (dedicated_irq_pin),
    .sampled (pinSampled),
    .rise    (pinRise),
    .fall    (pinFall)
  );

  wire epi_sense_t senseMode =
    epi_sense_t'(sense_power_ctrl_reg[SENSE_LSB +: 2]);
  wire levelMode = (senseMode == EPI_SENSE_LOW);

  logic pinTrigger;
  always_comb begin
    unique case (senseMode)
      EPI_SENSE_LOW:  pinTrigger = 1'b0;
      EPI_SENSE_ANY:  pinTrigger = pinRise | pinFall;
      EPI_SENSE_FALL: pinTrigger = pinFall;
      EPI_SENSE_RISE: pinTrigger = pinRise;
    endcase
  end

  // ==========================================================
  // Pin-change groups
  logic [2:0] grpChange;

  epi_change_group #(.WIDTH(GRP0_W)) uGrp0 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pins    (change_input[GRP0_W-1:0]),
    .mask    (change_mask_group0[GRP0_W-1:0]),
    .changed (grpChange[0])
  );
  epi_change_group #(.WIDTH(GRP1_W)) uGrp1 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pins    (change_input[GRP0_W +: GRP1_W]),
    .mask    (change_mask_group1[GRP1_W-1:0]),
    .changed (grpChange[1])
  );
  epi_change_group #(.WIDTH(GRP2_W)) uGrp2 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pins    (change_input[GRP0_W+GRP1_W +: GRP2_W]),
    .mask    (change_mask_group2[GRP2_W-1:0]),
    .changed (grpChange[2])
  );

  // Group enable also gates whether a change counts at all
  wire chg0 = grpChange[0] & irq_enable_reg[GRP0_BIT];
  wire chg1 = grpChange[1] & irq_enable_reg[GRP1_BIT];
  wire chg2 = grpChange[2] & irq_enable_reg[GRP2_BIT];

  // ==========================================================
  // Flag set and clear: set wins over clear
  wire ackPin  = vecAck && vecAckId == VEC_PIN;
  wire ackGrp0 = vecAck && vecAckId == VEC_GRP0;
  wire ackGrp1 = vecAck && vecAckId == VEC_GRP1;
  wire ackGrp2 = vecAck && vecAckId == VEC_GRP2;

  wire [7:0] setFlags = ({7'h00, pinTrigger} << PIN_BIT) |
                        ({7'h00, chg0} << GRP0_BIT) |
                        ({7'h00, chg1} << GRP1_BIT) |
                        ({7'h00, chg2} << GRP2_BIT);
  wire [7:0] ackFlags = ({7'h00, ackPin} << PIN_BIT) |
                        ({7'h00, ackGrp0} << GRP0_BIT) |
                        ({7'h00, ackGrp1} << GRP1_BIT) |
                        ({7'h00, ackGrp2} << GRP2_BIT);
  wire [7:0] clrFlags = ackFlags | (wrFlags ? wd : 8'h00);
  wire [7:0] pinForce = levelMode ? (8'h01 << PIN_BIT) : 8'h00;
  wire [7:0] next_flags =
    (((irq_flag_reg & ~clrFlags) | setFlags) & WMASK_GRP)
    & ~pinForce;

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      change_mask_group0   <= RESET_VAL;
      change_mask_group1   <= RESET_VAL;
      change_mask_group2   <= RESET_VAL;
      irq_enable_reg       <= RESET_VAL;
      irq_flag_reg         <= RESET_VAL;
      sense_power_ctrl_reg <= RESET_VAL;
    end else begin
      irq_flag_reg <= next_flags;
      if (wrMaskLow)  change_mask_group0 <= wd & WMASK_LOW;
      if (wrMaskMid)  change_mask_group1 <= wd & WMASK_MID;
      if (wrMaskHigh) change_mask_group2 <= wd & WMASK_HIGH;
      if (wrEnables)  irq_enable_reg <= wd & WMASK_GRP;
      if (wrSense)    sense_power_ctrl_reg <= wd & WMASK_SNS;
    end
  end

  // ==========================================================
  // Requests to the core
  wire levelReq = levelMode & ~pinSampled;
  assign coreRequest[0] = globalIrqEnable & irq_enable_reg[PIN_BIT] &
                          (irq_flag_reg[PIN_BIT] | levelReq);
  assign coreRequest[1] = globalIrqEnable & irq_enable_reg[GRP0_BIT] &
                          irq_flag_reg[GRP0_BIT];
  assign coreRequest[2] = globalIrqEnable & irq_enable_reg[GRP1_BIT] &
                          irq_flag_reg[GRP1_BIT];
  assign coreRequest[3] = globalIrqEnable & irq_enable_reg[GRP2_BIT] &
                          irq_flag_reg[GRP2_BIT];
  // Change groups are sampled each clock; no clockless path

  // ==========================================================
  // System interrupt status and mask
  wire [NUM_SRC-1:0] evt = {chg2, chg1, chg0, pinTrigger};
  wire [NUM_SRC-1:0] next_status =
    (eventStatus & ~(wrStat ? wd[NUM_SRC-1:0] : '0)) | evt;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      eventStatus <= '0;
      eventMask   <= '0;
    end else begin
      eventStatus <= next_status;
      if (wrIrqMask) eventMask <= wd[NUM_SRC-1:0];
    end
  end

  assign irqOut = |(eventStatus & eventMask);

  // ==========================================================
  // Read data
  logic [7:0] rdByte;
  always_comb begin
    unique case (dataIdx)
      IDX_MASK_LOW:  rdByte = change_mask_group0;
      IDX_MASK_MID:  rdByte = change_mask_group1;
      IDX_FLAGS:     rdByte = irq_flag_reg;
      IDX_ENABLES:   rdByte = irq_enable_reg;
      IDX_MASK_HIGH: rdByte = change_mask_group2;
      IDX_SENSE:     rdByte = sense_power_ctrl_reg;
      IDX_IRQ_STAT:  rdByte = {4'h0, eventStatus};
      IDX_IRQ_MASK:  rdByte = {4'h0, eventMask};
      default:       rdByte = 8'h00;
    endcase
  end
  assign hrdata = {24'h000000, rdByte};

  // ==========================================================
  // Checks
  default clocking chkClk @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  pin_rise_flag_a: assert property (
    (senseMode == EPI_SENSE_RISE && pinRise) |=> irq_flag_reg[PIN_BIT])
    else $error("rising edge did not set pin flag");
  pin_fall_flag_a: assert property (
    (senseMode == EPI_SENSE_FALL && pinFall) |=> irq_flag_reg[PIN_BIT])
    else $error("falling edge did not set pin flag");
  any_change_flag_a: assert property (
    (senseMode == EPI_SENSE_ANY && (pinRise || pinFall)) |=>
    irq_flag_reg[PIN_BIT])
    else $error("pin change did not set pin flag");
  fall_only_a: assert property (
    (senseMode == EPI_SENSE_FALL && !pinFall && !irq_flag_reg[PIN_BIT])
    |=> !irq_flag_reg[PIN_BIT])
    else $error("pin flag set without falling edge");
  rise_only_a: assert property (
    (senseMode == EPI_SENSE_RISE && !pinRise && !irq_flag_reg[PIN_BIT])
    |=> !irq_flag_reg[PIN_BIT])
    else $error("pin flag set without rising edge");
  level_clear_a: assert property (
    $past(levelMode) && levelMode |-> !irq_flag_reg[PIN_BIT])
    else $error("pin flag set in level mode");
  level_no_trig_a: assert property (
    levelMode |-> !pinTrigger)
    else $error("edge trigger in level mode");
  pin_req_gate_a: assert property (
    coreRequest[0] |-> globalIrqEnable && irq_enable_reg[PIN_BIT])
    else $error("pin request without enables");
  pin_req_flag_a: assert property (
    (globalIrqEnable && irq_enable_reg[PIN_BIT] && irq_flag_reg[PIN_BIT])
    |-> coreRequest[0])
    else $error("pending pin flag not requesting");
  level_req_a: assert property (
    (levelMode && !pinSampled && globalIrqEnable &&
     irq_enable_reg[PIN_BIT]) |-> coreRequest[0])
    else $error("low level not requesting");
  grp_flag_set_a: assert property (
    chg0 |=> irq_flag_reg[GRP0_BIT])
    else $error("group 0 change lost");
  grp1_flag_set_a: assert property (
    chg1 |=> irq_flag_reg[GRP1_BIT])
    else $error("group 1 change lost");
  grp2_flag_set_a: assert property (
    chg2 |=> irq_flag_reg[GRP2_BIT])
    else $error("group 2 change lost");
  chg_mask_a: assert property (
    grpChange[0] |-> change_mask_group0 != 8'h00)
    else $error("change counted with all pins masked");
  grp_gate_a: assert property (
    (!irq_enable_reg[GRP1_BIT] && !irq_flag_reg[GRP1_BIT]) |=>
    !irq_flag_reg[GRP1_BIT])
    else $error("disabled group set its flag");
  grp0_req_a: assert property (
    (globalIrqEnable && irq_enable_reg[GRP0_BIT] &&
     irq_flag_reg[GRP0_BIT]) |-> coreRequest[1])
    else $error("group 0 not requesting");
  grp1_req_a: assert property (
    (globalIrqEnable && irq_enable_reg[GRP1_BIT] &&
     irq_flag_reg[GRP1_BIT]) |-> coreRequest[2])
    else $error("group 1 not requesting");
  grp2_req_a: assert property (
    (globalIrqEnable && irq_enable_reg[GRP2_BIT] &&
     irq_flag_reg[GRP2_BIT]) |-> coreRequest[3])
    else $error("group 2 not requesting");
  ack_clear_a: assert property (
    (ackGrp1 && !chg1) |=> !irq_flag_reg[GRP1_BIT])
    else $error("acknowledge did not clear flag");
  pin_ack_clear_a: assert property (
    (ackPin && !pinTrigger) |=> !irq_flag_reg[PIN_BIT])
    else $error("acknowledge did not clear pin flag");
  grp0_ack_clear_a: assert property (
    (ackGrp0 && !chg0) |=> !irq_flag_reg[GRP0_BIT])
    else $error("acknowledge did not clear group 0");
  grp2_ack_clear_a: assert property (
    (ackGrp2 && !chg2) |=> !irq_flag_reg[GRP2_BIT])
    else $error("acknowledge did not clear group 2");
  w1c_clear_a: assert property (
    (wrFlags && wd[GRP2_BIT] && !chg2) |=> !irq_flag_reg[GRP2_BIT])
    else $error("write one did not clear flag");
  w1c_pin_a: assert property (
    (wrFlags && wd[PIN_BIT] && !pinTrigger) |=> !irq_flag_reg[PIN_BIT])
    else $error("write one did not clear pin flag");
  w1c_keep_a: assert property (
    (wrFlags && !wd[GRP0_BIT] && !ackGrp0 && irq_flag_reg[GRP0_BIT])
    |=> irq_flag_reg[GRP0_BIT])
    else $error("write zero cleared a flag");
  reserved_zero_a: assert property (
    (irq_flag_reg & ~WMASK_GRP) == 8'h00 &&
    (change_mask_group1 & ~WMASK_MID) == 8'h00)
    else $error("reserved bit set");
  rsvd_regs_a: assert property (
    (irq_enable_reg & ~WMASK_GRP) == 8'h00 &&
    (change_mask_group2 & ~WMASK_HIGH) == 8'h00 &&
    (sense_power_ctrl_reg & ~WMASK_SNS) == 8'h00)
    else $error("reserved control bit set");
  read_rsvd_a: assert property (
    hrdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  pin_sample_a: assert property (
    pinRise |-> pinSampled && !$past(pinSampled, 1))
    else $error("rise not from sampled pin");
  sample_track_a: assert property (
    $past(rst_n) |-> pinSampled == $past(dedicated_irq_pin))
    else $error("pin sample does not follow pin");
endmodule

// file: sim/epi_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Core side: takes requests, enters one handler at a time
module epi_core_model
  import epi_pkg::*;
#(
  parameter int DELAY = 3
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Requests in, handler entry out
  input  wire logic [3:0] coreRequest,
  input  wire logic       ackEnable,
  output logic            vecAck,
  output logic [1:0]      vecAckId
);
  logic [7:0] waitCnt;
  logic [1:0] pick;
  // Lowest vector wins, as in a fixed-priority core
  assign pick = coreRequest[0] ? VEC_PIN  :
                coreRequest[1] ? VEC_GRP0 :
                coreRequest[2] ? VEC_GRP1 : VEC_GRP2;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt  <= 8'h00;
      vecAck   <= 1'b0;
      vecAckId <= 2'h0;
    end else begin
      vecAck   <= 1'b0;
      // Id means nothing outside the strobe, so never leave it stable
      vecAckId <= ~vecAckId;
      if (ackEnable && (|coreRequest) && !vecAck) begin
        if (waitCnt == 8'(DELAY)) begin
          waitCnt  <= 8'h00;
          vecAck   <= 1'b1;
          vecAckId <= pick;
        end else begin
          waitCnt <= waitCnt + 8'h01;
        end
      end
    end
  end
endmodule

// file: sim/tb_external_pin_interrupt_unit.sv
`timescale 1ns/1ps
module tb_external_pin_interrupt_unit;
  import epi_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, irqOut, vecAck, globalIrqEnable = 1'b0;
  logic [31:0] hrdata, rd;
  logic        pinLevel = 1'b1;
  logic        ackEn = 1'b0;
  logic [17:0] chg = 18'h0;
  logic [1:0]  vecAckId;
  logic [3:0]  coreRequest;
  logic [7:0]  m0, m1, m2, en;
  int          miscompares = 0, n_checks = 0, acks = 0, p;
  logic [7:0]  idxs [8] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h1a, 8'h20,
                            8'h21, 8'h22};
  logic [7:0]  wms  [8] = '{8'hff, 8'h0f, 8'h00, 8'h71, 8'h3f, 8'hc0,
                            8'h00, 8'h0f};

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (vecAck === 1'b1) acks++;

  epi_ext_irq i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .dedicated_irq_pin(pinLevel),
    .change_input(chg), .globalIrqEnable(globalIrqEnable),
    .vecAck(vecAck), .vecAckId(vecAckId), .coreRequest(coreRequest),
    .irqOut(irqOut));
  epi_core_model #(.DELAY(3)) i_core (.clk_sys(clk_sys), .rst_n(rst_n),
    .coreRequest(coreRequest), .ackEnable(ackEn), .vecAck(vecAck),
    .vecAckId(vecAckId));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // Entered just after a rising edge, leaves at the data-phase edge
  task automatic bus(input logic [7:0] idx, input logic wr,
                     input logic [7:0] wd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] idx,
                       input logic [7:0] e);
    bus(idx, 1'b0, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic logic [7:0] exp_grp(input int pin);
    logic [17:0] msk;
    msk = {m2[5:0], m1[3:0], m0};
    if (pin < 8) return {1'b0, 2'b00, en[4] & msk[pin], 4'h0};
    if (pin < 12) return {2'b00, en[5] & msk[pin], 5'h0};
    return {1'b0, en[6] & msk[pin], 6'h0};
  endfunction

  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    tick(20000);
    miscompares++;
    results();
  end

  initial begin
    p = $urandom(45);
    tick(3);
    rst_n <= 1'b1;
    tick(1);
    for (int i = 0; i < 8; i++) rdchk("reset value", idxs[i], 8'h00);
    rdchk("unmapped", 8'h10, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(idxs[i], 8'hff);
      rdchk("writable bits", idxs[i], wms[i]);
      wr(idxs[i], 8'h00);
    end
    wr(IDX_ENABLES, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_SENSE, 8'(m << SENSE_LSB));
      wr(IDX_FLAGS, 8'h01);
      pinLevel <= 1'b0; // held low through the
      tick(4);
      rdchk("flag on fall", IDX_FLAGS, 8'(m == 1 || m == 2));
      if (m == 0) begin
        globalIrqEnable <= 1'b1;
        tick(2);
        chk("low level request", 32'h1, 32'(coreRequest[0]));
        globalIrqEnable <= 1'b0;
        tick(2);
        chk("request gated", 32'h0, 32'(coreRequest[0]));
      end
      wr(IDX_FLAGS, 8'h01);
      pinLevel <= 1'b1;
      tick(4);
      rdchk("flag on rise", IDX_FLAGS, 8'(m == 1 || m == 3));
    end
    // Event status and mask drive the level output
    wr(IDX_IRQ_STAT, 8'h0f);
    wr(IDX_IRQ_MASK, 8'h01);
    tick(1);
    chk("irq idle", 32'h0, 32'(irqOut));
    pinLevel <= 1'b0;
    tick(2);
    pinLevel <= 1'b1;
    tick(4);
    chk("irq on short pulse", 32'h1, 32'(irqOut));
    wr(IDX_IRQ_MASK, 8'h00);
    tick(1);
    chk("irq masked", 32'h0, 32'(irqOut));
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_IRQ_STAT, 8'h01);
    tick(1);
    chk("irq cleared", 32'h0, 32'(irqOut));
    for (int k = 0; k < 40; k++) begin
      m0 = (k == 0) ? 8'hff : 8'($urandom);
      m1 = 8'($urandom);
      m2 = 8'($urandom);
      en = (k == 0) ? 8'h70 : (k == 1) ? 8'h00 : 8'($urandom) & 8'h70;
      p = (k == 0) ? 0 : (k == 1) ? 17 : $urandom_range(17, 0);
      wr(IDX_MASK_LOW, m0);
      wr(IDX_MASK_MID, m1);
      wr(IDX_MASK_HIGH, m2);
      wr(IDX_ENABLES, en);
      wr(IDX_FLAGS, 8'h71);
      chg[p] <= ~chg[p];
      tick(2);
      chg[p] <= ~chg[p];
      tick(4);
      rdchk("group flag", IDX_FLAGS, exp_grp(p));
      wr(IDX_FLAGS, 8'h00);
      rdchk("flag kept on zero", IDX_FLAGS, exp_grp(p));
      chk("no request", 32'h0, 32'(coreRequest));
    end
    // Every source pending, then the core takes each in turn
    wr(IDX_MASK_LOW, 8'hff);
    wr(IDX_MASK_MID, 8'h0f);
    wr(IDX_MASK_HIGH, 8'h3f);
    wr(IDX_ENABLES, 8'h71);
    wr(IDX_SENSE, 8'h80);
    wr(IDX_FLAGS, 8'h71);
    chg <= chg ^ 18'h01101;
    pinLevel <= 1'b0;
    tick(4);
    rdchk("all pending", IDX_FLAGS, 8'h71);
    acks = 0;
    globalIrqEnable <= 1'b1;
    tick(2);
    chk("all requests", 32'hf, 32'(coreRequest));
    ackEn <= 1'b1;
    tick(40);
    chk("handler entries", 32'h4, 32'(acks));
    rdchk("cleared by entry", IDX_FLAGS, 8'h00);
    results();
  end
endmodule
